// ### rtl/bmsr_copy.sv
// Word copier: reads IMG_LAST+1 words from a source and writes them to a
// destination. Assumes source read data valid one cycle after the address.
`timescale 1ns/1ps
module bmsr_copy
(
    input  wire logic                       clk_i,
    input  wire logic                       reset_n_i,
    input  wire logic                       start_i,
    input  wire logic [bmsr_pkg::DATA_W-1:0] rd_data_i,
    output logic      [bmsr_pkg::ADDR_W-1:0] rd_addr_o,
    output logic      [bmsr_pkg::ADDR_W-1:0] wr_addr_o,
    output logic      [bmsr_pkg::DATA_W-1:0] wr_data_o,
    output logic                            wr_en_o,
    output logic                            done_o
);

    typedef struct packed {
        logic                        rd_act;
        logic [bmsr_pkg::ADDR_W-1:0] rd_addr;
        logic                        s1_act;
        logic [bmsr_pkg::ADDR_W-1:0] s1_addr;
        logic                        wr_en;
        logic [bmsr_pkg::ADDR_W-1:0] wr_addr;
        logic [bmsr_pkg::DATA_W-1:0] wr_data;
        logic                        done;
    } bmsr_copy_s;

    bmsr_copy_s q;
    bmsr_copy_s next_q;

    ////////////////////////////////////////////////////////////////////////
    // Read address walks, data trails it by two stages
    always_comb
    begin
        next_q         = q;
        next_q.s1_act  = q.rd_act;
        next_q.s1_addr = q.rd_addr;
        next_q.wr_en   = q.s1_act;
        next_q.wr_addr = q.s1_addr;
        next_q.wr_data = rd_data_i;
        next_q.done    = q.wr_en && (q.wr_addr == bmsr_pkg::IMG_LAST);
        if (start_i)
        begin
            next_q.rd_act  = 1'b1;
            next_q.rd_addr = '0;
        end
        else if (q.rd_act)
        begin
            if (q.rd_addr == bmsr_pkg::IMG_LAST)
                next_q.rd_act = 1'b0;
            else
                next_q.rd_addr = q.rd_addr + 7'h01;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            q <= '0;
        else
            q <= next_q;
    end

    assign rd_addr_o = q.rd_addr;
    assign wr_addr_o = q.wr_addr;
    assign wr_data_o = q.wr_data;
    assign wr_en_o   = q.wr_en;
    assign done_o    = q.done;

endmodule

// ### rtl/bmsr_core.sv
// Save/restore command interpreter for the battery-backed memory image.
// Assumes decoded commands and response framing on the same clock, and
// flash and backed memory with one-cycle registered reads.
`timescale 1ns/1ps
module bmsr_core
(
    input  wire logic                         clk_i,
    input  wire logic                         reset_n_i,
    input  wire logic                         cmd_valid_i,
    output logic                              cmd_ready_o,
    input  wire logic [1:0]                   cmd_code_i,
    input  wire logic [bmsr_pkg::PORT_W-1:0]  cmd_port_i,
    input  wire logic [7:0]                   reset_mode_i,
    input  wire logic [15:0]                  clear_mask_i,
    input  wire logic [bmsr_pkg::PORT_N-1:0]  port_filter_i,
    input  wire logic                         notice_en_i,
    input  wire logic                         text_en_i,
    output logic                              resp_valid_o,
    input  wire logic                         resp_ready_i,
    output logic      [2:0]                   resp_code_o,
    output logic                              resp_ok_o,
    output logic      [bmsr_pkg::PORT_W-1:0]  resp_port_o,
    output logic      [bmsr_pkg::ADDR_W-1:0]  flash_addr_o,
    output logic      [bmsr_pkg::DATA_W-1:0]  flash_wdata_o,
    output logic                              flash_we_o,
    input  wire logic [bmsr_pkg::DATA_W-1:0]  flash_rdata_i,
    input  wire logic                         flash_error_i,
    output logic      [bmsr_pkg::ADDR_W-1:0]  bbm_addr_o,
    output logic      [bmsr_pkg::DATA_W-1:0]  bbm_wdata_o,
    output logic                              bbm_we_o,
    input  wire logic [bmsr_pkg::DATA_W-1:0]  bbm_rdata_i,
    output logic                              nav_stopped_o,
    output logic                              image_present_o,
    output logic                              time_valid_o
);

    typedef struct packed {
        bmsr_pkg::bmsr_st_e          st;
        logic                        stopped;
        logic                        img;
        logic                        ferr;
        logic [bmsr_pkg::PORT_W-1:0] port;
        logic [2:0]                  pend;
        logic                        time_valid;
        logic                        rvalid;
        logic [2:0]                  rcode;
        logic                        rok;
        logic [bmsr_pkg::PORT_W-1:0] rport;
    } bmsr_core_s;

    bmsr_core_s q;
    bmsr_core_s next_q;

    logic                        cmd_take;
    logic                        mark_ok;
    logic                        restoring;
    logic                        cp_start;
    logic                        cp_done;
    logic                        cp_we;
    logic [bmsr_pkg::ADDR_W-1:0] cp_rd_addr;
    logic [bmsr_pkg::ADDR_W-1:0] cp_wr_addr;
    logic [bmsr_pkg::DATA_W-1:0] cp_wr_data;
    logic [bmsr_pkg::DATA_W-1:0] cp_src;

    ////////////////////////////////////////////////////////////////////////
    // Command handshake and marker check
    assign cmd_ready_o = (q.st == bmsr_pkg::ST_IDLE) && !q.rvalid;
    assign cmd_take    = cmd_valid_i && cmd_ready_o;
    assign mark_ok     = flash_rdata_i[bmsr_pkg::DATA_W-1:bmsr_pkg::MAGIC_LSB]
                         == bmsr_pkg::MARK_MAGIC;
    assign restoring   = (q.st == bmsr_pkg::ST_RESTORE);
    assign cp_start    = ((q.st == bmsr_pkg::ST_PEEK) && mark_ok)
                         || (q.st == bmsr_pkg::ST_INVAL);
    assign cp_src      = restoring ? flash_rdata_i : bbm_rdata_i;

    bmsr_copy u_copy
    (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .start_i   (cp_start),
        .rd_data_i (cp_src),
        .rd_addr_o (cp_rd_addr),
        .wr_addr_o (cp_wr_addr),
        .wr_data_o (cp_wr_data),
        .wr_en_o   (cp_we),
        .done_o    (cp_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: boot restore, backup, clear and response queue
    always_comb
    begin
        next_q = q;
        if (q.rvalid && resp_ready_i)
            next_q.rvalid = 1'b0;
        unique case (q.st)
            bmsr_pkg::ST_BOOT:
                next_q.st = bmsr_pkg::ST_PEEK;
            bmsr_pkg::ST_PEEK:
            begin
                if (mark_ok)
                begin
                    next_q.st   = bmsr_pkg::ST_RESTORE;
                    next_q.img  = 1'b1;
                    next_q.port = flash_rdata_i[bmsr_pkg::PORT_W-1:0];
                end
                else
                    next_q.st = bmsr_pkg::ST_IDLE;
            end
            bmsr_pkg::ST_RESTORE:
            begin
                if (cp_done)
                begin
                    next_q.time_valid = 1'b0;
                    next_q.pend = {text_en_i, notice_en_i,
                                   port_filter_i[q.port]};
                    next_q.st   = bmsr_pkg::ST_REPORT;
                end
            end
            bmsr_pkg::ST_REPORT:
            begin
                if (!q.rvalid || resp_ready_i)
                begin
                    next_q.rport = q.port;
                    next_q.rok   = 1'b1;
                    if (q.pend[0])
                    begin
                        next_q.rvalid  = 1'b1;
                        next_q.rcode   = bmsr_pkg::RESP_RESTORED;
                        next_q.pend[0] = 1'b0;
                    end
                    else if (q.pend[1])
                    begin
                        next_q.rvalid  = 1'b1;
                        next_q.rcode   = bmsr_pkg::RESP_NOTICE;
                        next_q.pend[1] = 1'b0;
                    end
                    else if (q.pend[2])
                    begin
                        next_q.rvalid  = 1'b1;
                        next_q.rcode   = bmsr_pkg::RESP_TEXT;
                        next_q.pend[2] = 1'b0;
                    end
                    else
                        next_q.st = bmsr_pkg::ST_IDLE;
                end
            end
            bmsr_pkg::ST_IDLE:
            begin
                if (cmd_take)
                begin
                    next_q.rport = cmd_port_i;
                    unique case (cmd_code_i)
                        bmsr_pkg::CMD_RESET:
                            next_q.stopped =
                                (reset_mode_i == bmsr_pkg::STOP_MODE)
                                && (clear_mask_i == bmsr_pkg::HOT_MASK);
                        bmsr_pkg::CMD_BACKUP:
                        begin
                            if (q.stopped)
                            begin
                                next_q.st   = bmsr_pkg::ST_INVAL;
                                next_q.port = cmd_port_i;
                                next_q.ferr = 1'b0;
                                next_q.img  = 1'b0;
                            end
                            else
                            begin
                                next_q.rvalid = 1'b1;
                                next_q.rcode  = bmsr_pkg::RESP_BACKUP_ACK;
                                next_q.rok    = 1'b0;
                            end
                        end
                        bmsr_pkg::CMD_CLEAR:
                        begin
                            if (q.img)
                                next_q.st = bmsr_pkg::ST_ERASE;
                            else
                            begin
                                next_q.rvalid = 1'b1;
                                next_q.rcode  = bmsr_pkg::RESP_NEG_ACK;
                                next_q.rok    = 1'b0;
                            end
                        end
                        bmsr_pkg::CMD_TIME:
                            next_q.time_valid = 1'b1;
                    endcase
                end
            end
            bmsr_pkg::ST_INVAL:
                next_q.st = bmsr_pkg::ST_BACKUP;
            bmsr_pkg::ST_BACKUP:
            begin
                if (flash_error_i)
                    next_q.ferr = 1'b1;
                if (cp_done)
                begin
                    if (q.ferr || flash_error_i)
                    begin
                        next_q.st     = bmsr_pkg::ST_IDLE;
                        next_q.rvalid = 1'b1;
                        next_q.rcode  = bmsr_pkg::RESP_BACKUP_ACK;
                        next_q.rok    = 1'b0;
                    end
                    else
                        next_q.st = bmsr_pkg::ST_MARK;
                end
            end
            bmsr_pkg::ST_MARK:
            begin
                next_q.st     = bmsr_pkg::ST_IDLE;
                next_q.rvalid = 1'b1;
                next_q.rcode  = bmsr_pkg::RESP_BACKUP_ACK;
                next_q.rok    = !flash_error_i;
                next_q.img    = !flash_error_i;
            end
            bmsr_pkg::ST_ERASE:
            begin
                next_q.st     = bmsr_pkg::ST_IDLE;
                next_q.rvalid = 1'b1;
                next_q.img    = 1'b0;
                next_q.rok    = !flash_error_i;
                next_q.rcode  = flash_error_i ? bmsr_pkg::RESP_NEG_ACK
                                              : bmsr_pkg::RESP_POS_ACK;
            end
            default:
                next_q.st = bmsr_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            q <= '0;
        else
            q <= next_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory port steering; marker shares the flash port with the copy
    always_comb
    begin
        flash_addr_o  = restoring ? cp_rd_addr : cp_wr_addr;
        flash_wdata_o = cp_wr_data;
        flash_we_o    = (q.st == bmsr_pkg::ST_BACKUP) && cp_we;
        if (q.st inside {bmsr_pkg::ST_BOOT, bmsr_pkg::ST_PEEK,
                         bmsr_pkg::ST_INVAL, bmsr_pkg::ST_ERASE,
                         bmsr_pkg::ST_MARK})
            flash_addr_o = bmsr_pkg::MARK_ADDR;
        if (q.st inside {bmsr_pkg::ST_INVAL, bmsr_pkg::ST_ERASE})
        begin
            flash_wdata_o = bmsr_pkg::ERASED;
            flash_we_o    = 1'b1;
        end
        if (q.st == bmsr_pkg::ST_MARK)
        begin
            flash_wdata_o = {bmsr_pkg::MARK_MAGIC, q.port};
            flash_we_o    = 1'b1;
        end
    end

    assign bbm_addr_o  = restoring ? cp_wr_addr : cp_rd_addr;
    assign bbm_wdata_o = cp_wr_data;
    assign bbm_we_o    = restoring && cp_we;

    assign resp_valid_o    = q.rvalid;
    assign resp_code_o     = q.rcode;
    assign resp_ok_o       = q.rok;
    assign resp_port_o     = q.rport;
    assign nav_stopped_o   = q.stopped;
    assign image_present_o = q.img;
    assign time_valid_o    = q.time_valid;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    restore_write_a : assert property (@(posedge clk_i)
        disable iff (!reset_n_i) bbm_we_o |-> q.st == bmsr_pkg::ST_RESTORE)
        else $error("backed memory written outside restore");
    time_clear_a : assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        (restoring && cp_done) |=> !time_valid_o)
        else $error("time valid after restore");
    backup_cause_a : assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        (q.st == bmsr_pkg::ST_INVAL) |->
        $past(cmd_take && cmd_code_i == bmsr_pkg::CMD_BACKUP))
        else $error("backup without command");
    boot_restore_a : assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        (q.st == bmsr_pkg::ST_PEEK && mark_ok) |=> restoring ##66 cp_done)
        else $error("stored image not restored");
    stop_mode_a : assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        (cmd_take && cmd_code_i == bmsr_pkg::CMD_RESET
         && reset_mode_i != bmsr_pkg::STOP_MODE) |=> !nav_stopped_o)
        else $error("stop taken from wrong reset mode");
    backup_ack_a : assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        (q.st == bmsr_pkg::ST_INVAL) |-> ##[68:69] (resp_valid_o
        && resp_code_o == bmsr_pkg::RESP_BACKUP_ACK))
        else $error("backup ack missing");
    restored_port_a : assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        (resp_valid_o && resp_code_o == bmsr_pkg::RESP_RESTORED)
        |-> resp_port_o == q.port)
        else $error("restored report on wrong port");
    silent_boot_a : assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        (q.st == bmsr_pkg::ST_PEEK && !mark_ok) |=> !resp_valid_o ##0
        q.st == bmsr_pkg::ST_IDLE)
        else $error("report without stored image");
    notice_gate_a : assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        (resp_valid_o && resp_code_o == bmsr_pkg::RESP_NOTICE)
        |-> $past(q.st) == bmsr_pkg::ST_REPORT)
        else $error("notice outside restore");
    clear_answer_a : assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        (cmd_take && cmd_code_i == bmsr_pkg::CMD_CLEAR) |-> ##[1:2]
        (resp_valid_o && resp_code_o inside {bmsr_pkg::RESP_POS_ACK,
                                             bmsr_pkg::RESP_NEG_ACK}))
        else $error("clear not answered");
    one_image_a : assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        (q.st == bmsr_pkg::ST_BACKUP) |-> !image_present_o)
        else $error("old image kept during backup");

endmodule

// ### rtl/bmsr_pkg.sv
// Constants, codes and state encodings for the backed-memory save/restore
// block. Assumes a command framer and response framer on the same clock.
package bmsr_pkg;

    localparam int DATA_W = 16;
    localparam int ADDR_W = 7;
    localparam int PORT_W = 2;
    localparam int PORT_N = 4;

    // Image occupies words 0..IMG_LAST, the marker word follows it
    localparam logic [ADDR_W-1:0] IMG_LAST  = 7'h3F;
    localparam logic [ADDR_W-1:0] MARK_ADDR = 7'h40;
    // Marker word: magic in [15:2], saved command port in [1:0]
    localparam int              MAGIC_LSB  = 2;
    localparam logic [13:0]     MARK_MAGIC = 14'h1A5C;
    localparam logic [DATA_W-1:0] ERASED   = 16'h0000;

    localparam logic [7:0]  STOP_MODE = 8'h08;
    localparam logic [15:0] HOT_MASK  = 16'h0000;

    typedef enum logic [1:0] {
        CMD_RESET  = 2'b00,
        CMD_BACKUP = 2'b01,
        CMD_CLEAR  = 2'b10,
        CMD_TIME   = 2'b11
    } bmsr_cmd_e;

    typedef enum logic [2:0] {
        RESP_BACKUP_ACK = 3'b000,
        RESP_RESTORED   = 3'b001,
        RESP_NOTICE     = 3'b010,
        RESP_TEXT       = 3'b011,
        RESP_POS_ACK    = 3'b100,
        RESP_NEG_ACK    = 3'b101
    } bmsr_resp_e;

    typedef enum logic [3:0] {
        ST_BOOT    = 4'b0000,
        ST_PEEK    = 4'b0001,
        ST_RESTORE = 4'b0010,
        ST_REPORT  = 4'b0011,
        ST_IDLE    = 4'b0100,
        ST_INVAL   = 4'b0101,
        ST_BACKUP  = 4'b0110,
        ST_MARK    = 4'b0111,
        ST_ERASE   = 4'b1000
    } bmsr_st_e;

endpackage

// ### tb/bmsr_mem_model.sv
// Memory model standing for the flash and for the backed memory.
// Assumes one client on clk_i and a one-cycle registered read.
`timescale 1ns/1ps
module bmsr_mem_model
#(
    parameter logic [15:0] BASE = 16'h0000
)
(
    input  wire logic        clk_i,
    input  wire logic        wipe_i,
    input  wire logic        we_i,
    input  wire logic [6:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    output logic      [15:0] rdata_o
);
    logic [15:0] mem [0:127];

    // Preload: zero base means an erased part, else address pattern
    initial
    begin
        for (int i = 0; i < 128; i++)
            mem[i] = (BASE == 16'h0000) ? 16'h0000 : (BASE | 16'(i));
    end

    ////////////////////////////////////////////////////////////////////////
    // Wipe stands for losing the backup supply while powered off
    always_ff @(posedge clk_i)
    begin
        if (wipe_i)
            for (int i = 0; i < 128; i++)
                mem[i] <= 16'h5A5A;
        else if (we_i)
            mem[addr_i] <= wdata_i;
        rdata_o <= mem[addr_i];
    end
endmodule

// ### tb/test_backup_memory_save_restore.sv
// Self-checking bench for the save/restore command interpreter.
// Assumes bmsr_core and the memory model; host side driven here.
`timescale 1ns/1ps
module test_backup_memory_save_restore;
    logic        clk_i, reset_n_i, cmd_valid, resp_ready, flash_err, wipe;
    logic [1:0]  cmd_code, cmd_port, resp_port;
    logic [7:0]  mode;
    logic [15:0] mask, f_wd, f_rd, b_wd, b_rd;
    logic [6:0]  f_addr, b_addr;
    logic [2:0]  resp_code;
    logic        cmd_ready, resp_valid, resp_ok, f_we, b_we;
    logic        stopped, img, tvalid;
    logic [3:0]  filt;
    logic        ntc_en, txt_en;
    int          n_fail, total_checks;

    bmsr_core uut (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
        .cmd_code_i(cmd_code), .cmd_port_i(cmd_port), .reset_mode_i(mode),
        .clear_mask_i(mask), .port_filter_i(filt), .notice_en_i(ntc_en),
        .text_en_i(txt_en), .resp_valid_o(resp_valid),
        .resp_ready_i(resp_ready), .resp_code_o(resp_code),
        .resp_ok_o(resp_ok), .resp_port_o(resp_port),
        .flash_addr_o(f_addr), .flash_wdata_o(f_wd), .flash_we_o(f_we),
        .flash_rdata_i(f_rd), .flash_error_i(flash_err),
        .bbm_addr_o(b_addr), .bbm_wdata_o(b_wd), .bbm_we_o(b_we),
        .bbm_rdata_i(b_rd), .nav_stopped_o(stopped),
        .image_present_o(img), .time_valid_o(tvalid));
    bmsr_mem_model #(.BASE(16'h0000)) flash_m (.clk_i(clk_i),
        .wipe_i(1'b0), .we_i(f_we), .addr_i(f_addr), .wdata_i(f_wd),
        .rdata_o(f_rd));
    bmsr_mem_model #(.BASE(16'hA000)) bbm_m (.clk_i(clk_i),
        .wipe_i(wipe), .we_i(b_we), .addr_i(b_addr), .wdata_i(b_wd),
        .rdata_o(b_rd));

    // Clock at 40 MHz
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check_eq(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        if (n_fail == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Reset held three edges, stands for a power cycle
    task automatic power_up();
        reset_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
    endtask

    // Request held until an edge sees ready high
    task automatic send_cmd(input logic [1:0] c, input logic [1:0] p,
                            input logic [7:0] m, input logic [15:0] k);
        @(posedge clk_i);
        cmd_valid <= 1'b1;
        cmd_code  <= c;
        cmd_port  <= p;
        mode      <= m;
        mask      <= k;
        @(negedge clk_i);
        for (int i = 0; i < 300 && cmd_ready !== 1'b1; i++)
            @(negedge clk_i);
        check_eq(16'(cmd_ready), 16'h0001);
        @(posedge clk_i);
        cmd_valid <= 1'b0;
    endtask

    // Response left stalled a cycle, then accepted
    task automatic expect_resp(input bmsr_pkg::bmsr_resp_e c,
                               input logic ok);
        @(negedge clk_i);
        for (int i = 0; i < 300 && resp_valid !== 1'b1; i++)
            @(negedge clk_i);
        check_eq({12'h0000, resp_valid, resp_code}, {12'h0000, 1'b1, c});
        if (c != bmsr_pkg::RESP_NOTICE && c != bmsr_pkg::RESP_TEXT)
            check_eq(16'(resp_ok), 16'(ok));
        if (c == bmsr_pkg::RESP_RESTORED)
            check_eq(16'(resp_port), 16'h0002); // saved port
        @(posedge clk_i);
        resp_ready <= 1'b1;
        @(posedge clk_i);
        resp_ready <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Boot with an empty flash: ready soon, nothing reported
    task automatic t_boot_empty();
        for (int i = 0; i < 10 && cmd_ready !== 1'b1; i++)
            @(negedge clk_i);
        check_eq(16'(cmd_ready), 16'h0001);
        check_eq({14'h0000, resp_valid, img}, 16'h0000);
    endtask

    // Backup after the stop is cancelled by another reset mode is answered as failed
    task automatic t_refuse();
        send_cmd(bmsr_pkg::CMD_RESET, 2'h1, 8'h08, 16'h0000);
        send_cmd(bmsr_pkg::CMD_RESET, 2'h1, 8'h01, 16'h0000);
        @(negedge clk_i);
        check_eq(16'(stopped), 16'h0000);
        send_cmd(bmsr_pkg::CMD_BACKUP, 2'h1, 8'h00, 16'h0000);
        expect_resp(bmsr_pkg::RESP_BACKUP_ACK, 1'b0);
        check_eq(16'(img), 16'h0000);
    endtask

    // Stop, then backup; a flash fault leaves no image
    task automatic t_backup(input logic err);
        send_cmd(bmsr_pkg::CMD_TIME, 2'h2, 8'h00, 16'h0000);
        flash_err <= err;
        // Levels update on the take edge, so look half a cycle later
        @(negedge clk_i);
        check_eq(16'(tvalid), 16'h0001);
        send_cmd(bmsr_pkg::CMD_RESET, 2'h2, 8'h08, 16'h0000);
        @(negedge clk_i);
        check_eq(16'(stopped), 16'h0001);
        send_cmd(bmsr_pkg::CMD_BACKUP, 2'h2, 8'h00, 16'h0000);
        expect_resp(bmsr_pkg::RESP_BACKUP_ACK, !err);
        flash_err <= 1'b0;
        check_eq(16'(img), 16'(!err));
        for (int i = 0; i < 64 && !err; i++)
            check_eq(flash_m.mem[i], 16'hA000 | 16'(i));
    endtask

    // Power cycle with lost backed memory brings the image back
    task automatic t_restore();
        wipe <= 1'b1;
        @(posedge clk_i);
        wipe <= 1'b0;
        power_up(); // only after the ack
        expect_resp(bmsr_pkg::RESP_RESTORED, 1'b1);
        expect_resp(bmsr_pkg::RESP_NOTICE, 1'b1);
        expect_resp(bmsr_pkg::RESP_TEXT, 1'b1);
        for (int i = 0; i < 64; i++)
            check_eq(bbm_m.mem[i], 16'hA000 | 16'(i));
        check_eq(16'(tvalid), 16'h0000);
    endtask

    // Clear answered positive with an image, negative without
    task automatic t_clear();
        send_cmd(bmsr_pkg::CMD_CLEAR, 2'h2, 8'h00, 16'h0000);
        expect_resp(bmsr_pkg::RESP_POS_ACK, 1'b1);
        check_eq(16'(img), 16'h0000);
        send_cmd(bmsr_pkg::CMD_CLEAR, 2'h2, 8'h00, 16'h0000);
        expect_resp(bmsr_pkg::RESP_NEG_ACK, 1'b0);
    endtask

    // Gated reports: filter shut with notice off, then text off
    task automatic t_restore_gated();
        t_backup(1'b0);
        filt   <= 4'hB;
        ntc_en <= 1'b0;
        power_up(); // only after the ack
        expect_resp(bmsr_pkg::RESP_TEXT, 1'b1);
        @(negedge clk_i);
        check_eq({14'h0000, resp_valid, cmd_ready}, 16'h0001);
        @(posedge clk_i);
        filt   <= 4'hF;
        ntc_en <= 1'b1;
        txt_en <= 1'b0;
        power_up(); // only after the ack
        expect_resp(bmsr_pkg::RESP_RESTORED, 1'b1);
        expect_resp(bmsr_pkg::RESP_NOTICE, 1'b1);
        @(negedge clk_i);
        check_eq({14'h0000, resp_valid, cmd_ready}, 16'h0001);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        n_fail = 0;
        total_checks = 0;
        {cmd_valid, resp_ready, flash_err, wipe} = 4'h0;
        {cmd_code, cmd_port, mode, mask} = 28'h000_0000;
        {filt, ntc_en, txt_en} = 6'h3F;
        power_up();
        t_boot_empty();
        t_refuse();
        t_backup(1'b1);
        t_backup(1'b0);
        t_backup(1'b0); // second image replaces first
        t_restore();
        t_clear();
        t_restore_gated();
        wrap_up();
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        #(25 * 20000);
        n_fail++;
        wrap_up();
    end
endmodule
